// ---- design/bscr_pkg.sv ----
// Package of constants for the board control and status register file
package bscr_pkg;

	// ****************************************
	// Register decode
	// ****************************************
	localparam int          ADDR_W          = 3;
	localparam int          DATA_W          = 32;
	localparam logic [2:0]  IDX_STATUS      = 3'h2;
	localparam logic [2:0]  IDX_CONTROL     = 3'h3;
	localparam logic [2:0]  IDX_PCI         = 3'h4;
	localparam logic [7:0]  OFS_STATUS      = 8'h08;
	localparam logic [7:0]  OFS_CONTROL     = 8'h0C;
	localparam logic [7:0]  OFS_PCI         = 8'h10;

	// ****************************************
	// Tool/board status field positions
	// ****************************************
	localparam int          ST_TOOL_STAT    = 0;
	localparam int          ST_TOOL_REV     = 8;
	localparam int          ST_TOOL_ID      = 12;
	localparam int          ST_SWOPT_HI     = 16;
	localparam int          ST_BOARD_VER    = 20;
	localparam int          ST_BOARD_REV    = 22;
	localparam int          ST_SWOPT_LO     = 24;
	localparam int          ST_FLASH_DLY    = 25;
	localparam int          ST_FLASH_TYPE   = 28;

	// ****************************************
	// Control field positions and reset values
	// ****************************************
	localparam int          CT_USB_EN       = 0;
	localparam int          CT_USB_SPEED    = 1;
	localparam int          CT_USB_POWER    = 2;
	localparam int          CT_ETH2_INIT    = 3;
	localparam int          CT_ETH2_RST     = 4;
	localparam int          CT_UTOPIA_W     = 5;
	localparam int          CT_UTOPIA_PHY   = 6;
	localparam int          CT_LBUS_MODE    = 7;
	localparam int          CT_WR_W         = 7;
	localparam logic [6:0]  CT_RESET        = 7'h79;

	// ****************************************
	// PCI status field positions
	// ****************************************
	localparam int          PS_SLOT0        = 0;
	localparam int          PS_SLOT1        = 2;
	localparam int          PS_SLOT2        = 4;
	localparam int          PS_FAST         = 6;
	localparam int          PS_CLK_SET      = 7;

	// ****************************************
	// Synchronised pin vector layout
	// ****************************************
	localparam int          PN_TOOL_STAT    = 0;
	localparam int          PN_TOOL_REV     = 8;
	localparam int          PN_TOOL_ID      = 12;
	localparam int          PN_SWOPT_HI     = 16;
	localparam int          PN_SWOPT_LO     = 18;
	localparam int          PN_FLASH_DLY    = 19;
	localparam int          PN_FLASH_TYPE   = 22;
	localparam int          PN_SLOTS        = 26;
	localparam int          PN_FAST         = 32;
	localparam int          PN_CLK_SET      = 33;
	localparam int          PN_LBUS_MODE    = 34;
	localparam int          PN_PROCESSOR_HARD_RESET_N_N     = 35;
	localparam int          PIN_W           = 36;
	localparam logic [35:0] PIN_RESET       = 36'h800000000;

	// ****************************************
	// Hard-wired board codes (arbitrary values)
	// ****************************************
	localparam logic [1:0]  BOARD_VER_CODE  = 2'h1;
	localparam logic [1:0]  BOARD_REV_CODE  = 2'h0;

endpackage : bscr_pkg

// ---- design/bscr_pin_sync.sv ----
// Two-stage synchroniser for the board pin inputs
`timescale 1ns/10ps
`default_nettype none

module bscr_pin_sync (
	input  wire logic                    mclk,
	input  wire logic                    reset_n,
	input  wire logic [bscr_pkg::PIN_W-1:0] pin_async,
	output logic      [bscr_pkg::PIN_W-1:0] pin_sync
);
	import bscr_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] stage1;
		logic [PIN_W-1:0] stage2;
	} bscr_sync_s;

	bscr_sync_s sync_ff;
	bscr_sync_s nxt_sync;

	// ****************************************
	// Two flip-flop chain
	// ****************************************
	always_comb begin
		nxt_sync        = sync_ff;
		nxt_sync.stage1 = pin_async;
		nxt_sync.stage2 = sync_ff.stage1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sync_ff <= {PIN_RESET, PIN_RESET};
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign pin_sync = sync_ff.stage2;

endmodule // bscr_pin_sync

`default_nettype wire

// ---- design/bscr_regs.sv ----
// Board control and status registers: tool/board status, port control, PCI status
//
// Overview of operation
// - Tool/board status register, read-only, at byte offset 8.
// - Status bits 0-7 show eight external tool status inputs.
// - Status bits 8-11 show the four-bit external tool revision.
// - Status bits 12-15 show the tool identification lines; F means no tool.
// - Software option: upper bits at 16-17, low bit at 24, default zero.
// - Status bits 20-21 return a hard-wired board version code.
// - Status bits 22-23 return a hard-wired board revision code.
// - Status bits 25-27 mirror the flash delay presence-detect lines.
// - Status bits 28-31 mirror the flash type presence-detect lines.
// - Read-write control register at byte offset 0xC.
// - Control bit 0 is active-low USB enable, default 1; high puts USB in standby.
// - Control bit 2, default 0: high connects bus power to the USB port.
// - Control bit 3, default 1: Ethernet 2 initial enable, sampled only while the PHY reset is asserted.
// - Control bit 4, default 1: Ethernet 2 PHY reset, also forced by hard reset.
// - Control bit 5, default 1: low selects 16-bit UTOPIA, high 8-bit.
// - Control bit 6, default 1: low selects multi-PHY, high single-PHY.
// - Control bit 7 is read-only and reports the local bus mode.
// - PCI status register, read-only, at byte offset 0x10.
// - Bit pairs 0-1, 2-3, 4-5 report slot-present codes of slots 0 to 2.
// - PCI status bit 6 reads 1 when all boards are 66MHz capable.
// - PCI status bit 7 reflects the PCI bus clock setting input.
// - Only three address lines are decoded, so registers repeat in the region.
`timescale 1ns/10ps
`default_nettype none

module bscr_regs (
	input  wire logic                       mclk,
	input  wire logic                       reset_n,
	input  wire logic                       regfile_enable,
	input  wire logic                       bus_cs_n,
	input  wire logic                       bus_rd_wr_n,
	input  wire logic [bscr_pkg::ADDR_W-1:0] bus_addr,
	input  wire logic [bscr_pkg::DATA_W-1:0] bus_wdata,
	output logic      [bscr_pkg::DATA_W-1:0] bus_rdata,
	output logic                            bus_ack,
	input  wire logic [7:0]                 tool_status_field,
	input  wire logic [3:0]                 tool_revision_field,
	input  wire logic [3:0]                 tool_ident_field,
	input  wire logic [1:0]                 sw_option_high,
	input  wire logic                       sw_option_low,
	input  wire logic [2:0]                 flash_delay_detect,
	input  wire logic [3:0]                 flash_type_detect,
	input  wire logic [1:0]                 slot0_present_code,
	input  wire logic [1:0]                 slot1_present_code,
	input  wire logic [1:0]                 slot2_present_code,
	input  wire logic                       all_boards_fast_capable,
	input  wire logic                       pci_clock_setting,
	input  wire logic                       local_bus_mode,
	input  wire logic                       processor_hard_reset_n,
	output logic                            usb_enable_n,
	output logic                            usb_speed_select_n,
	output logic                            usb_power_on,
	output logic                            eth2_initial_enable_n,
	output logic                            eth2_phy_reset_n,
	output logic                            utopia_width_select_n,
	output logic                            utopia_phy_mode_n
);
	import bscr_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                cs_prev_n;
		logic [CT_WR_W-1:0]  ctrl;
		logic                eth2_init_n;
		logic                eth2_rst_n;
		logic [DATA_W-1:0]   rdata;
		logic                ack;
	} bscr_state_s;

	bscr_state_s        st_ff;
	bscr_state_s        nxt_st;
	logic [PIN_W-1:0]   pin_s;
	logic               access;
	logic               wr_access;
	logic               rd_access;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	bscr_pin_sync u_pin_sync (
		.mclk      (mclk),
		.reset_n   (reset_n),
		.pin_async ({processor_hard_reset_n, local_bus_mode, pci_clock_setting,
		             all_boards_fast_capable, slot2_present_code, slot1_present_code,
		             slot0_present_code, flash_type_detect, flash_delay_detect,
		             sw_option_low, sw_option_high, tool_ident_field,
		             tool_revision_field, tool_status_field}),
		.pin_sync  (pin_s)
	);

	// ****************************************
	// Read word assembly
	// ****************************************
	function automatic logic [DATA_W-1:0] read_word(
		input logic [ADDR_W-1:0]  idx,
		input logic [CT_WR_W-1:0] ctrl,
		input logic [PIN_W-1:0]   p
	);
		logic [DATA_W-1:0] w;
		w = '0;
		case (idx)
			IDX_STATUS: begin
				w[ST_TOOL_STAT +: 8]  = p[PN_TOOL_STAT +: 8];
				w[ST_TOOL_REV +: 4]   = p[PN_TOOL_REV +: 4];
				w[ST_TOOL_ID +: 4]    = p[PN_TOOL_ID +: 4];
				w[ST_SWOPT_HI +: 2]   = p[PN_SWOPT_HI +: 2];
				w[ST_SWOPT_LO]        = p[PN_SWOPT_LO];
				w[ST_BOARD_VER +: 2]  = BOARD_VER_CODE;
				w[ST_BOARD_REV +: 2]  = BOARD_REV_CODE;
				w[ST_FLASH_DLY +: 3]  = p[PN_FLASH_DLY +: 3];
				w[ST_FLASH_TYPE +: 4] = p[PN_FLASH_TYPE +: 4];
			end
			IDX_CONTROL: begin
				w[CT_WR_W-1:0]        = ctrl;
				w[CT_LBUS_MODE]       = p[PN_LBUS_MODE];
			end
			IDX_PCI: begin
				w[PS_SLOT0 +: 6]      = p[PN_SLOTS +: 6];
				w[PS_FAST]            = p[PN_FAST];
				w[PS_CLK_SET]         = p[PN_CLK_SET];
			end
			default: begin
				w = '0;
			end
		endcase
		return w;
	endfunction

	// ****************************************
	// Access decode
	// ****************************************
	always_comb begin
		access    = regfile_enable && !bus_cs_n && st_ff.cs_prev_n;
		wr_access = access && !bus_rd_wr_n;
		rd_access = access && bus_rd_wr_n;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st           = st_ff;
		nxt_st.cs_prev_n = bus_cs_n;
		nxt_st.ack       = access;
		if (wr_access && (bus_addr == IDX_CONTROL)) begin
			nxt_st.ctrl = bus_wdata[CT_WR_W-1:0];
		end
		if (rd_access) begin
			nxt_st.rdata = read_word(bus_addr, st_ff.ctrl, pin_s);
		end
		nxt_st.eth2_rst_n = st_ff.ctrl[CT_ETH2_RST] && pin_s[PN_PROCESSOR_HARD_RESET_N_N];
		if (!st_ff.eth2_rst_n) begin
			nxt_st.eth2_init_n = st_ff.ctrl[CT_ETH2_INIT];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st_ff.cs_prev_n   <= 1'b1;
			st_ff.ctrl        <= CT_RESET;
			st_ff.eth2_init_n <= 1'b1;
			st_ff.eth2_rst_n  <= 1'b0;
			st_ff.rdata       <= '0;
			st_ff.ack         <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus_rdata             = st_ff.rdata;
	assign bus_ack               = st_ff.ack;
	assign usb_enable_n          = st_ff.ctrl[CT_USB_EN];
	assign usb_speed_select_n    = st_ff.ctrl[CT_USB_SPEED];
	assign usb_power_on          = st_ff.ctrl[CT_USB_POWER];
	assign eth2_initial_enable_n = st_ff.eth2_init_n;
	assign eth2_phy_reset_n      = st_ff.eth2_rst_n;
	assign utopia_width_select_n = st_ff.ctrl[CT_UTOPIA_W];
	assign utopia_phy_mode_n     = st_ff.ctrl[CT_UTOPIA_PHY];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	property p_ctrl_write;
		wr_access && (bus_addr == IDX_CONTROL)
			|=> (usb_enable_n == $past(bus_wdata[0])) && (usb_power_on == $past(bus_wdata[2]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

	property p_utopia_width;
		wr_access && (bus_addr == IDX_CONTROL)
			|=> utopia_width_select_n == $past(bus_wdata[5]);
	endproperty
	a_utopia_width: assert property (p_utopia_width) else $error("utopia width wrong");

	property p_ro_write;
		wr_access && (bus_addr != IDX_CONTROL) |=> $stable(st_ff.ctrl);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("read-only write changed control");

	property p_ctrl_upper_zero;
		rd_access && (bus_addr == IDX_CONTROL) ##1 bus_ack |-> bus_rdata[31:8] == 24'h000000;
	endproperty
	a_ctrl_upper_zero: assert property (p_ctrl_upper_zero) else $error("reserved bits set");

	property p_lbus_mode;
		rd_access && (bus_addr == IDX_CONTROL) |=> bus_rdata[7] == $past(pin_s[PN_LBUS_MODE]);
	endproperty
	a_lbus_mode: assert property (p_lbus_mode) else $error("local bus mode wrong");

	property p_slot_codes;
		rd_access && (bus_addr == IDX_PCI) |=> bus_rdata[5:0] == $past(pin_s[PN_SLOTS +: 6]);
	endproperty
	a_slot_codes: assert property (p_slot_codes) else $error("slot codes wrong");

	property p_board_codes;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[23:20] == {BOARD_REV_CODE, BOARD_VER_CODE};
	endproperty
	a_board_codes: assert property (p_board_codes) else $error("board codes wrong");

	property p_hard_reset;
		!pin_s[PN_PROCESSOR_HARD_RESET_N_N] |=> !eth2_phy_reset_n;
	endproperty
	a_hard_reset: assert property (p_hard_reset) else $error("PHY not reset");

	property p_init_hold;
		eth2_phy_reset_n && $past(eth2_phy_reset_n) |-> $stable(eth2_initial_enable_n);
	endproperty
	a_init_hold: assert property (p_init_hold) else $error("initial enable moved");

	property p_ack_pulse;
		access |=> bus_ack ##1 !bus_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one cycle");

	property p_tool_status;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_TOOL_STAT +: 8] == $past(pin_s[PN_TOOL_STAT +: 8]);
	endproperty
	a_tool_status: assert property (p_tool_status) else $error("tool status wrong");

	property p_tool_rev;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_TOOL_REV +: 4] == $past(pin_s[PN_TOOL_REV +: 4]);
	endproperty
	a_tool_rev: assert property (p_tool_rev) else $error("tool revision wrong");

	property p_tool_ident;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_TOOL_ID +: 4] == $past(pin_s[PN_TOOL_ID +: 4]);
	endproperty
	a_tool_ident: assert property (p_tool_ident) else $error("tool ident wrong");

	property p_sw_option;
		rd_access && (bus_addr == IDX_STATUS)
			|=> (bus_rdata[ST_SWOPT_HI +: 2] == $past(pin_s[PN_SWOPT_HI +: 2]))
			&& (bus_rdata[ST_SWOPT_LO] == $past(pin_s[PN_SWOPT_LO]));
	endproperty
	a_sw_option: assert property (p_sw_option) else $error("software option wrong");

	property p_status_reserved;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_SWOPT_HI + 2 +: 2] == 2'h0;
	endproperty
	a_status_reserved: assert property (p_status_reserved) else $error("status gap set");

	property p_flash_delay;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_FLASH_DLY +: 3] == $past(pin_s[PN_FLASH_DLY +: 3]);
	endproperty
	a_flash_delay: assert property (p_flash_delay) else $error("flash delay wrong");

	property p_flash_type;
		rd_access && (bus_addr == IDX_STATUS)
			|=> bus_rdata[ST_FLASH_TYPE +: 4] == $past(pin_s[PN_FLASH_TYPE +: 4]);
	endproperty
	a_flash_type: assert property (p_flash_type) else $error("flash type wrong");

	property p_fast_capable;
		rd_access && (bus_addr == IDX_PCI) |=> bus_rdata[PS_FAST] == $past(pin_s[PN_FAST]);
	endproperty
	a_fast_capable: assert property (p_fast_capable) else $error("fast flag wrong");

	property p_clk_setting;
		rd_access && (bus_addr == IDX_PCI) |=> bus_rdata[PS_CLK_SET] == $past(pin_s[PN_CLK_SET]);
	endproperty
	a_clk_setting: assert property (p_clk_setting) else $error("clock setting wrong");

	property p_unused_zero;
		rd_access && (bus_addr != IDX_STATUS) && (bus_addr != IDX_CONTROL)
			&& (bus_addr != IDX_PCI) |=> bus_rdata == '0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("unused index not zero");

	property p_ctrl_readback;
		rd_access && (bus_addr == IDX_CONTROL)
			|=> (bus_rdata[CT_USB_POWER:CT_USB_EN]
				== {usb_power_on, usb_speed_select_n, usb_enable_n})
			&& (bus_rdata[CT_UTOPIA_PHY:CT_UTOPIA_W]
				== {utopia_phy_mode_n, utopia_width_select_n});
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

	property p_usb_speed;
		wr_access && (bus_addr == IDX_CONTROL)
			|=> usb_speed_select_n == $past(bus_wdata[CT_USB_SPEED]);
	endproperty
	a_usb_speed: assert property (p_usb_speed) else $error("usb speed wrong");

	property p_phy_mode;
		wr_access && (bus_addr == IDX_CONTROL)
			|=> utopia_phy_mode_n == $past(bus_wdata[CT_UTOPIA_PHY]);
	endproperty
	a_phy_mode: assert property (p_phy_mode) else $error("phy mode wrong");

	property p_phy_reset_ctrl;
		!st_ff.ctrl[CT_ETH2_RST] |=> !eth2_phy_reset_n;
	endproperty
	a_phy_reset_ctrl: assert property (p_phy_reset_ctrl) else $error("PHY reset not driven");

	property p_init_follow;
		!eth2_phy_reset_n |=> eth2_initial_enable_n == $past(st_ff.ctrl[CT_ETH2_INIT]);
	endproperty
	a_init_follow: assert property (p_init_follow) else $error("initial enable stale");

	property p_no_ack_disabled;
		!regfile_enable |=> !bus_ack;
	endproperty
	a_no_ack_disabled: assert property (p_no_ack_disabled) else $error("ack while disabled");

	c_ctrl_write: cover property (wr_access && (bus_addr == IDX_CONTROL));
	c_status_read: cover property (rd_access && (bus_addr == IDX_STATUS));
	c_phy_reset: cover property (!pin_s[PN_PROCESSOR_HARD_RESET_N_N] ##1 !eth2_phy_reset_n);
	c_pci_read: cover property (rd_access && (bus_addr == IDX_PCI));
	c_init_latch: cover property (!eth2_phy_reset_n ##1 eth2_phy_reset_n);

endmodule // bscr_regs

`default_nettype wire

// ---- verification/bscr_host_model.sv ----
// Host memory controller model driving single chip-select cycles
`timescale 1ns/10ps
`default_nettype none

module bscr_host_model (
	input  wire logic                        mclk,
	output logic                             bus_cs_n,
	output logic                             bus_rd_wr_n,
	output logic      [bscr_pkg::ADDR_W-1:0] bus_addr,
	output logic      [bscr_pkg::DATA_W-1:0] bus_wdata,
	input  wire logic [bscr_pkg::DATA_W-1:0] bus_rdata,
	input  wire logic                        bus_ack
);
	import bscr_pkg::*;

	// ****************************************
	// Idle bus and single access
	// ****************************************
	initial begin
		bus_cs_n = 1'b1;
		bus_rd_wr_n = 1'b1;
		bus_addr = '0;
		bus_wdata = '0;
	end

	// Holds the request until ack is sampled or six cycles pass, then releases with lines inverted
	task automatic access(input logic rd, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rdat, output logic acked);
		int n;
		acked = 1'b0;
		rdat = '0;
		@(posedge mclk);
		bus_cs_n <= 1'b0;
		bus_rd_wr_n <= rd;
		bus_addr <= a;
		bus_wdata <= wd;
		for (n = 0; n < 6 && !acked; n++) begin
			@(posedge mclk);
			if (bus_ack === 1'b1) begin
				acked = 1'b1;
				rdat = bus_rdata;
			end
		end
		bus_cs_n <= 1'b1;
		bus_rd_wr_n <= ~rd;
		bus_addr <= ~a;
		bus_wdata <= ~wd;
	endtask

endmodule // bscr_host_model

`default_nettype wire

// ---- verification/test_board_status_control_regs.sv ----
// Self-checking testbench of the board control and status registers
`timescale 1ns/10ps
`default_nettype none

module test_board_status_control_regs;
	import bscr_pkg::*;

	typedef struct packed {
		logic [7:0]  ts;
		logic [3:0]  rev;
		logic [3:0]  id;
		logic [1:0]  swh;
		logic        swl;
		logic [2:0]  fd;
		logic [3:0]  ft;
		logic [5:0]  sl;
		logic        fast;
		logic        clks;
		logic        lb;
		logic [31:0] st;
		logic [31:0] pci;
		logic [31:0] ct;
	} bscr_row_s;

	logic        mclk, reset_n, regfile_enable, bus_cs_n, bus_rd_wr_n, bus_ack;
	logic [2:0]  bus_addr;
	logic [31:0] bus_wdata, bus_rdata, d;
	logic [7:0]  ts;
	logic [3:0]  trev, tid, ft;
	logic [2:0]  fd;
	logic [1:0]  swh;
	logic [5:0]  sl;
	logic        swl, fast, clks, lb, hrst_n, ak;
	logic        usb_en_n, spd_n, pwr, init_n, phy_rst_n, wid_n, mode_n;
	logic [6:0]  ctl_pins;
	int          num_errors, cmp_count, i;
	bscr_row_s   rows [3];

	assign ctl_pins = {mode_n, wid_n, phy_rst_n, init_n, pwr, spd_n, usb_en_n};

	bscr_regs bscr_regs_inst (.mclk(mclk), .reset_n(reset_n), .regfile_enable(regfile_enable),
		.bus_cs_n(bus_cs_n), .bus_rd_wr_n(bus_rd_wr_n), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
		.tool_status_field(ts), .tool_revision_field(trev), .tool_ident_field(tid),
		.sw_option_high(swh), .sw_option_low(swl), .flash_delay_detect(fd),
		.flash_type_detect(ft), .slot0_present_code(sl[1:0]), .slot1_present_code(sl[3:2]),
		.slot2_present_code(sl[5:4]), .all_boards_fast_capable(fast),
		.pci_clock_setting(clks), .local_bus_mode(lb), .processor_hard_reset_n(hrst_n),
		.usb_enable_n(usb_en_n), .usb_speed_select_n(spd_n), .usb_power_on(pwr),
		.eth2_initial_enable_n(init_n), .eth2_phy_reset_n(phy_rst_n),
		.utopia_width_select_n(wid_n), .utopia_phy_mode_n(mode_n));

	bscr_host_model bscr_host_model_inst (.mclk(mclk), .bus_cs_n(bus_cs_n),
		.bus_rd_wr_n(bus_rd_wr_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack));

	// ****************************************
	// Checking and bus tasks
	// ****************************************
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pins(input logic [6:0] exp);
		@(posedge mclk);
		cmp_count++;
		if (ctl_pins !== exp) begin
			num_errors++;
			$display("wrong value at %0t: pins %h expected %h", $time, ctl_pins, exp);
		end
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
		bscr_host_model_inst.access(1'b1, a, 32'h0, d, ak);
		chk_word({31'h0, ak}, 32'h1);
		chk_word(d, exp);
	endtask

	task automatic wr(input logic [2:0] a, input logic [31:0] wd);
		bscr_host_model_inst.access(1'b0, a, wd, d, ak);
		chk_word({31'h0, ak}, 32'h1);
	endtask

	task automatic report_and_stop;
		if (num_errors == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, watchdog and main sequence
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		#(50 * 3000);
		num_errors++;
		report_and_stop;
	end

	initial begin
		rows[0] = '{8'hA5, 4'h2, 4'hF, 2'h3, 1'b1, 3'h4, 4'h2, 6'h3F, 1'b1, 1'b0, 1'b1,
			32'h2913F2A5, 32'h0000007F, 32'h000000F9};
		rows[1] = '{8'h5A, 4'h0, 4'h0, 2'h0, 1'b0, 3'h1, 4'h0, 6'h24, 1'b0, 1'b1, 1'b0,
			32'h0210005A, 32'h000000A4, 32'h00000079};
		rows[2] = '{8'hFF, 4'hF, 4'h2, 2'h1, 1'b0, 3'h7, 4'hF, 6'h13, 1'b1, 1'b1, 1'b1,
			32'hFE112FFF, 32'h000000D3, 32'h000000F9};
		num_errors = 0;
		cmp_count = 0;
		reset_n = 1'b0;
		regfile_enable = 1'b1;
		hrst_n = 1'b1;
		{ts, trev, tid, swh, swl, fd, ft, sl, fast, clks, lb} = '0;
		repeat (3) @(posedge mclk);
		chk_pins(7'h69);
		reset_n <= 1'b1;
		repeat (3) @(posedge mclk);
		chk_pins(7'h79);
		for (i = 0; i < 3; i++) begin
			@(posedge mclk);
			{ts, trev, tid, swh, swl, fd, ft, sl, fast, clks, lb} <= rows[i][130:96];
			repeat (4) @(posedge mclk);
			rd_chk(3'h2, rows[i].st);
			rd_chk(3'h4, rows[i].pci);
			rd_chk(3'h3, rows[i].ct);
		end
		wr(3'h3, 32'h00000069);
		chk_pins(7'h69);
		wr(3'h3, 32'hFFFFFF86);
		chk_pins(7'h06);
		rd_chk(3'h3, 32'h00000086);
		wr(3'h3, 32'h00000008);
		chk_pins(7'h08);
		wr(3'h3, 32'h00000018);
		wr(3'h3, 32'h00000010);
		chk_pins(7'h18);
		@(posedge mclk);
		hrst_n <= 1'b0;
		repeat (4) @(posedge mclk);
		chk_pins(7'h00);
		hrst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_pins(7'h10);
		wr(3'h2, 32'h0);
		wr(3'h4, 32'h0);
		rd_chk(3'h2, 32'hFE112FFF);
		rd_chk(3'h4, 32'h000000D3);
		for (i = 0; i < 8; i++) begin
			if (i < 2 || i > 4) begin
				wr(i[2:0], 32'hFFFFFFFF);
				rd_chk(i[2:0], 32'h0);
			end
		end
		rd_chk(3'h3, 32'h00000090);
		@(posedge mclk);
		regfile_enable <= 1'b0;
		bscr_host_model_inst.access(1'b0, 3'h3, 32'h00000079, d, ak);
		chk_word({31'h0, ak}, 32'h0);
		bscr_host_model_inst.access(1'b1, 3'h3, 32'h0, d, ak);
		chk_word({31'h0, ak}, 32'h0);
		regfile_enable <= 1'b1;
		chk_pins(7'h10);
		rd_chk(3'h3, 32'h00000090);
		reset_n <= 1'b0;
		chk_pins(7'h69);
		reset_n <= 1'b1;
		repeat (2) @(posedge mclk);
		chk_pins(7'h79);
		rd_chk(3'h3, 32'h000000F9);
		report_and_stop;
	end

endmodule // test_board_status_control_regs

`default_nettype wire
